//--- core/mem_arbiter.sv
// Hierarchical weighted main-memory arbiter with refresh and priority raise
`timescale 1ns/1ps
`include "arb_defs.svh"

module mem_arbiter
  import arb_pkg::*;
#(
  parameter int N_UNIT = 10,
  parameter int N_L6   = 5
)
(
  input  wire logic              ref_clk_i,
  input  wire logic              rst_i,
  input  wire logic [31:0]       reg_addr_i,
  input  wire logic [31:0]       reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [31:0]       reg_rdata_o,
  input  wire logic              cpu_mmio_req_i,
  input  wire logic              cpu_dcache_req_i,
  input  wire logic              cpu_icache_req_i,
  input  wire logic              cpu_reorder_i,
  input  wire logic [N_UNIT-1:1] unit_req_i,
  input  wire logic [1:0]        cpu_ticks_i,
  input  wire logic [3:0]        rt_overflow_i,
  input  wire logic [3:0]        rt_underflow_i,
  output logic      [N_UNIT-1:0] ack_o,
  output logic      [1:0]        cpu_src_o,
  output logic                   mem_start_o,
  output logic      [3:0]        mem_unit_o,
  output logic      [6:0]        mem_bytes_o,
  output logic                   refresh_o,
  output logic                   irq_o
);
  localparam int N_LVL = N_UNIT - N_L6;

  logic [`ARB_WEIGHT_BITS-1:0] weight_reg;
  logic [15:0]                 raise_reg;
  logic [N_UNIT-1:0]           unit_en;
  logic [15:0]                 refr_interval;
  logic [7:0]                  irq_status;
  logic [7:0]                  irq_mask;
  slot_state_e                 state;
  logic [4:0]                  elap;
  logic [4:0]                  slot_len;
  logic                        pend_valid;
  logic [3:0]                  pend_unit;
  logic                        pend_reorder;
  logic [15:0]                 refr_cnt;
  logic                        refr_due;
  logic [N_UNIT-1:0]           raised;
  logic [N_UNIT-1:0]           base_req;
  logic [N_UNIT-1:0]           eff_req;
  logic [3:0]                  win;
  logic                        decide;
  logic                        cpu_any;
  logic [1:0]                  cpu_pick;
  weight_t                     w_own [N_LVL];
  weight_t                     w_low [N_LVL];
  logic [1:0]                  c6 [N_L6];
  logic [N_L6-1:0]             l6_has;
  logic                        l6_reload;
  logic [3:0]                  l6_win;
  logic [N_LVL-1:0]            pick_vec;

  arb_level_if lv [N_LVL] ();

  // Register write port; weights reset to code zero, all weights one
  wire wr_hit_weight = reg_wr_i && reg_addr_i == `ARB_WEIGHT_OFF;
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      weight_reg    <= `ARB_WEIGHT_RST;
      raise_reg     <= `PRIORITY_RAISE_DELAY_REGISTER_RST;
      unit_en       <= `ARB_ENABLE_RST;
      refr_interval <= 16'(`ARB_REFR_CYC);
      irq_mask      <= `ARB_MASK_RST;
    end
    else if (reg_wr_i)
    begin
      if (wr_hit_weight)
        weight_reg <= reg_wdata_i[`ARB_WEIGHT_BITS-1:0];
      if (reg_addr_i == `PRIORITY_RAISE_DELAY_REGISTER_OFF)
        raise_reg <= reg_wdata_i[15:0];
      if (reg_addr_i == `ARB_ENABLE_OFF)
        unit_en <= reg_wdata_i[N_UNIT-1:0];
      if (reg_addr_i == `ARB_REFRESH_OFF)
        refr_interval <= reg_wdata_i[15:0];
      if (reg_addr_i == `ARB_MASK_OFF)
        irq_mask <= reg_wdata_i[7:0];
    end
  end

  // Exception flags: a new event beats a same-cycle write-one clear
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      irq_status <= 8'h00;
    else
      irq_status <= {rt_underflow_i, rt_overflow_i}
                  | (irq_status & ~((reg_wr_i && reg_addr_i == `ARB_STATUS_OFF)
                                    ? reg_wdata_i[7:0] : 8'h00));
  end

  assign irq_o = |(irq_status & irq_mask);

  // Read port, data one cycle after the strobe; unmapped reads as zero
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      reg_rdata_o <= 32'h0000_0000;
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        `ARB_WEIGHT_OFF:  reg_rdata_o <= {14'h0000, weight_reg};
        `PRIORITY_RAISE_DELAY_REGISTER_OFF:   reg_rdata_o <= {16'h0000, raise_reg};
        `ARB_ENABLE_OFF:  reg_rdata_o <= {22'h00_0000, unit_en};
        `ARB_REFRESH_OFF: reg_rdata_o <= {16'h0000, refr_interval};
        `ARB_STATUS_OFF:  reg_rdata_o <= {24'h00_0000, irq_status};
        `ARB_MASK_OFF:    reg_rdata_o <= {24'h00_0000, irq_mask};
        `ARB_STATE_OFF:   reg_rdata_o <= {14'h0000, raised, pend_unit, pend_valid, refr_due,
                                          state};
        default:          reg_rdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // Processor sources merged with fixed priority: register, data, instruction
  assign cpu_any  = cpu_mmio_req_i || cpu_dcache_req_i || cpu_icache_req_i;
  assign cpu_pick = cpu_mmio_req_i ? 2'h0 : (cpu_dcache_req_i ? 2'h1 : 2'h2);

  // Disabled units drop out, which is the same as a zero weight
  assign base_req = {unit_req_i, cpu_any} & unit_en;

  // Raise timers: only the four units with a delay field start low
  genvar u;
  generate
    for (u = 0; u < N_UNIT; u++)
    begin : g_raise
      localparam int FLD = (u == 1) ? 0 : (u == 3) ? 1 : (u == 4) ? 2 : (u == 5) ? 3 : -1;
      if (FLD < 0)
      begin : g_fixed
        assign raised[u] = 1'b1;
      end
      else
      begin : g_timed
        logic [11:0] wait_cnt;
        wire  [11:0] thr = {raise_reg[FLD*4 +: 4], 8'h00} >> 4;
        // Counts processor cycles, 16 per delay step
        always_ff @(posedge ref_clk_i or posedge rst_i)
        begin
          if (rst_i)
            wait_cnt <= 12'h000;
          else if (!base_req[u] || ack_o[u])
            wait_cnt <= 12'h000;
          else if (!raised[u])
            wait_cnt <= wait_cnt + 12'(cpu_ticks_i);
        end
        assign raised[u] = wait_cnt >= thr;
      end
    end
  endgenerate

  // Raised requests win over low ones; with none raised all compete
  assign eff_req = |(base_req & raised) ? (base_req & raised) : base_req;

  // Per-level weights; a disabled level side gets weight zero
  always_comb
  begin
    w_own[0] = 3'(weight_reg[`ARB_W_CPU_LSB +: 2]) + 3'h1;
    w_low[0] = 3'(weight_reg[`ARB_W_L2_LSB +: 2]) + 3'h1;
    w_own[1] = {weight_reg[`ARB_W_VO_LSB +: 2], 1'b1};
    w_low[1] = {weight_reg[`ARB_W_L3_LSB +: 2], 1'b1};
    w_own[2] = {weight_reg[`ARB_W_ICP_LSB +: 2], 1'b1};
    w_low[2] = {weight_reg[`ARB_W_L4_LSB +: 2], 1'b1};
    w_own[3] = {2'b00, weight_reg[`ARB_W_VI_BIT]} + 3'h1;
    w_low[3] = {weight_reg[`ARB_W_L5_LSB +: 2], 1'b1};
    w_own[4] = {weight_reg[`ARB_W_PCI_LSB +: 2], 1'b1};
    w_low[4] = {2'b00, weight_reg[`ARB_W_L6_BIT]} + 3'h1;
  end

  // Five two-way levels in a chain, each sees everything below as one side
  genvar l;
  generate
    for (l = 0; l < N_LVL; l++)
    begin : g_lvl
      assign lv[l].own_req = eff_req[l];
      assign lv[l].low_req = |(eff_req >> (l + 1));
      assign lv[l].w_own   = unit_en[l] ? w_own[l] : 3'h0;
      assign lv[l].w_low   = |(unit_en >> (l + 1)) ? w_low[l] : 3'h0;
      assign lv[l].take    = decide && (win >= 4'(l));
      // Flattened so the winner search can index it with a loop variable
      assign pick_vec[l]   = lv[l].pick_own;
      arb_level u_level (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .lv        (lv[l])
      );
    end
  endgenerate

  // Lowest level: credits per unit, U_VLD two, the rest one
  always_comb
  begin
    l6_win = 4'(N_LVL);
    for (int j = 0; j < N_L6; j++)
      l6_has[j] = eff_req[N_LVL + j] && (c6[j] != 2'h0);
    l6_reload = !(|l6_has);
    for (int j = N_L6 - 1; j >= 0; j--)
      if (l6_reload ? eff_req[N_LVL + j] : l6_has[j])
        l6_win = 4'(N_LVL + j);
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      for (int j = 0; j < N_L6; j++)
        c6[j] <= 2'h0;
    else if (decide && win >= 4'(N_LVL))
      for (int j = 0; j < N_L6; j++)
        if (l6_reload)
          c6[j] <= ((j == 0) ? 2'h2 : 2'h1) - ((4'(N_LVL + j) == win) ? 2'h1 : 2'h0);
        else if (4'(N_LVL + j) == win)
          c6[j] <= c6[j] - 2'h1;
  end

  // Winner: first level whose own side is picked, else the lowest level
  always_comb
  begin
    win = l6_win;
    for (int i = N_LVL - 1; i >= 0; i--)
      if (pick_vec[i])
        win = 4'(i);
  end

  // Decision at idle, or sixteen cycles into the running transaction
  assign decide = !pend_valid && (|eff_req) && (state == ST_IDLE
                  || (state == ST_XFER && elap >= 5'(`ARB_DECIDE_CYC)));

  // One acknowledge per decision, held request is released by it
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ack_o     <= '0;
      cpu_src_o <= 2'h0;
    end
    else
    begin
      ack_o <= decide ? (N_UNIT'(1) << win) : '0;
      if (decide && win == U_CPU)
        cpu_src_o <= cpu_pick;
    end
  end

  // Refresh interval counter; a zero interval stops refresh
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      refr_cnt <= 16'h0000;
    else if (refr_interval == 16'h0000 || refr_cnt >= refr_interval - 16'h0001)
      refr_cnt <= 16'h0000;
    else
      refr_cnt <= refr_cnt + 16'h0001;
  end

  // Slot sequencer: refresh first, then the pending grant
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state        <= ST_IDLE;
      elap         <= 5'h00;
      slot_len     <= 5'h00;
      pend_valid   <= 1'b0;
      pend_unit    <= 4'h0;
      pend_reorder <= 1'b0;
      refr_due     <= 1'b0;
      refresh_o    <= 1'b0;
      mem_start_o  <= 1'b0;
      mem_unit_o   <= 4'h0;
      mem_bytes_o  <= 7'h00;
    end
    else
    begin
      refresh_o   <= 1'b0;
      mem_start_o <= 1'b0;
      if (refr_interval != 16'h0000 && refr_cnt >= refr_interval - 16'h0001)
        refr_due <= 1'b1; // New tick wins over the take below
      else if (state == ST_IDLE && refr_due)
        refr_due <= 1'b0;
      if (decide)
      begin
        pend_valid   <= 1'b1;
        pend_unit    <= win;
        pend_reorder <= (win == U_CPU) && cpu_reorder_i;
      end
      case (state)
        ST_IDLE:
        begin
          elap <= 5'h00;
          if (refr_due)
          begin
            state     <= ST_REFR;
            slot_len  <= 5'(`ARB_REFR_TXN_CYC);
            refresh_o <= 1'b1;
          end
          else if (pend_valid)
          begin
            state       <= ST_XFER;
            pend_valid  <= 1'b0;
            slot_len    <= pend_reorder ? 5'(`ARB_TXN_CYC + `ARB_REORDER_CYC)
                                        : 5'(`ARB_TXN_CYC);
            mem_start_o <= 1'b1;
            mem_unit_o  <= pend_unit;
            mem_bytes_o <= 7'(`ARB_XFER_BYTES);
          end
        end
        ST_XFER, ST_REFR:
        begin
          elap <= elap + 5'h01;
          if (elap >= slot_len - 5'h01)
            state <= ST_IDLE;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  ack_single_a: assert property ($onehot0(ack_o))
    else $error("more than one acknowledge");
  no_idle_a: assert property ((state == ST_IDLE && !pend_valid && |eff_req) |=> |ack_o)
    else $error("request left waiting on an idle bus");
  refr_first_a: assert property ((state == ST_IDLE && refr_due) |=> refresh_o && !mem_start_o)
    else $error("refresh did not take the free slot");
  refr_len_a: assert property (refresh_o |=> (state == ST_REFR)[*8])
    else $error("refresh slot ended early");
  slot_len_a: assert property (mem_start_o |-> slot_len == (pend_reorder
                               ? 5'd30 : 5'd20))
    else $error("transaction slot length wrong");
  xfer_size_a: assert property (mem_start_o |-> mem_bytes_o == 7'd64)
    else $error("transfer size not sixty-four bytes");
  disabled_a: assert property (|ack_o |-> |(ack_o & unit_en))
    else $error("disabled unit acknowledged");
  fixed_unit_a: assert property (ack_o[U_ICP] |-> $past(raised[U_ICP]))
    else $error("unit without delay held low");
  early_decide_a: assert property ((state == ST_XFER && elap < 5'd16) |-> !decide)
    else $error("decision before sixteen cycles");
  cpu_prio_a: assert property ((ack_o[U_CPU] && $past(cpu_mmio_req_i)) |-> cpu_src_o == 2'h0)
    else $error("register access lost fixed priority");
  flag_set_a: assert property (rt_overflow_i[0] |=> irq_status[0])
    else $error("overflow flag not set");

  cpu_reorder_c: cover property (mem_start_o && pend_reorder);
  raise_c: cover property (ack_o[U_VO] && raised[U_VO]);
  refresh_c: cover property (refresh_o ##[1:40] mem_start_o);
endmodule : mem_arbiter

//--- common/arb_defs.svh
// Register offsets, field positions, reset values and timing counts of the arbiter
`ifndef ARB_DEFS_SVH
`define ARB_DEFS_SVH

// Register byte offsets
`define PRIORITY_RAISE_DELAY_REGISTER_OFF      32'h0010_0100
`define ARB_WEIGHT_OFF     32'h0010_0104
`define ARB_ENABLE_OFF     32'h0010_0110
`define ARB_REFRESH_OFF    32'h0010_0114
`define ARB_STATUS_OFF     32'h0010_0118
`define ARB_MASK_OFF       32'h0010_011C
`define ARB_STATE_OFF      32'h0010_0120

// Weight register field positions (low bit of each field)
`define ARB_W_CPU_LSB      16
`define ARB_W_L2_LSB       14
`define ARB_W_VO_LSB       12
`define ARB_W_L3_LSB       10
`define ARB_W_ICP_LSB      8
`define ARB_W_L4_LSB       6
`define ARB_W_VI_BIT       5
`define ARB_W_L5_LSB       3
`define ARB_W_PCI_LSB      1
`define ARB_W_L6_BIT       0
`define ARB_WEIGHT_BITS    18

// Reset values
`define ARB_WEIGHT_RST     18'h0_0000
`define PRIORITY_RAISE_DELAY_REGISTER_RST      16'h0000
`define ARB_ENABLE_RST     10'h3FF
`define ARB_MASK_RST       8'h00

// Timing in SDRAM cycles; raise step in processor cycles, size in bytes, period and window in ns
`define ARB_TXN_CYC        20
`define ARB_REORDER_CYC    10
`define ARB_REFR_TXN_CYC   19
`define ARB_DECIDE_CYC     16
`define PRIORITY_RAISE_DELAY_REGISTER_UNIT     16
`define ARB_XFER_BYTES     64
`define ARB_CLK_PERIOD_NS  8
`define ARB_REFR_WINDOW_NS 64000000
`define ARB_REFR_COUNT     4096
// Longest interval: rounded down to whole cycles
`define ARB_REFR_CYC       (`ARB_REFR_WINDOW_NS / `ARB_CLK_PERIOD_NS / `ARB_REFR_COUNT)

`endif

//--- common/arb_pkg.sv
// Types shared by the memory arbiter modules
package arb_pkg;
  // Bus slot state, Gray coded along idle -> transfer -> refresh
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_XFER = 2'b01,
    ST_REFR = 2'b11
  } slot_state_e;
  // Requester index, hierarchy order from top to bottom
  typedef enum logic [3:0] {
    U_CPU  = 4'h0,
    U_VO   = 4'h1,
    U_ICP  = 4'h2,
    U_VI   = 4'h3,
    U_PCI  = 4'h4,
    U_VLD  = 4'h5,
    U_AI   = 4'h6,
    U_AO   = 4'h7,
    U_DISC_DECODER_UNIT = 4'h8,
    U_BOOT = 4'h9
  } unit_e;
  typedef logic [2:0] weight_t;
endpackage : arb_pkg

//--- common/arb_level_if.sv
// Signals between the arbiter core and one two-way hierarchy level
`timescale 1ns/1ps
interface arb_level_if;
  import arb_pkg::*;
  logic    own_req;
  logic    low_req;
  logic    take;
  weight_t w_own;
  weight_t w_low;
  logic    pick_own;
  modport ctl (output own_req, low_req, take, w_own, w_low, input pick_own);
  modport lvl (input own_req, low_req, take, w_own, w_low, output pick_own);
endinterface : arb_level_if

//--- core/arb_level.sv
// One hierarchy level: weighted round robin between its unit and the levels below
`timescale 1ns/1ps
module arb_level
  import arb_pkg::*;
(
  input  wire logic   ref_clk_i,
  input  wire logic   rst_i,
  arb_level_if.lvl    lv
);
  weight_t c_own;
  weight_t c_low;

  // Own side wins alone, or while it has credit, or when both sides are spent
  assign lv.pick_own = lv.own_req && (!lv.low_req || (c_own != 3'h0) || (c_low == 3'h0));

  // Credits only move when both sides contend; lone requests take free slots
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      c_own <= 3'h0;
      c_low <= 3'h0;
    end
    else if (lv.take && lv.own_req && lv.low_req)
    begin
      if (lv.pick_own && c_own != 3'h0)
        c_own <= c_own - 3'h1;
      else if (lv.pick_own)
      begin
        c_own <= lv.w_own - 3'h1; // Reload round, own slot spent now
        c_low <= lv.w_low;
      end
      else
        c_low <= c_low - 3'h1;
    end
  end

  alone_wins_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (lv.own_req && !lv.low_req) |-> lv.pick_own)
    else $error("level idles its only requester");
  share_bound_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (lv.own_req && lv.low_req && c_own == 3'h0 && c_low != 3'h0) |-> !lv.pick_own)
    else $error("own unit exceeds its weight share");
endmodule : arb_level

//--- dv/req_model.sv
// Requesting units model: holds requests until acknowledged, then waits for data
`timescale 1ns/1ps
module req_model
  import arb_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  input  wire logic [9:0] want_i,
  input  wire logic [9:0] fast_i,
  input  wire logic [9:0] ack_i,
  output logic      [9:0] req_o
);
  logic [4:0] wait_q [10];

  // Per unit: raise, hold to ack, then a data wait (short only for saturating units)
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      req_o <= 10'h000;
      for (int u = 0; u < 10; u++) wait_q[u] <= 5'h00;
    end
    else
    begin
      for (int u = 0; u < 10; u++)
      begin
        if (ack_i[u])
        begin
          req_o[u]  <= 1'b0;
          wait_q[u] <= fast_i[u] ? 5'h01 : 5'h18;
        end
        else if (wait_q[u] != 5'h00)
          wait_q[u] <= wait_q[u] - 5'h01;
        else if (want_i[u])
          req_o[u] <= 1'b1;
      end
    end
  end
endmodule : req_model

//--- dv/tb.sv
// Self-checking bench for the memory arbiter
`timescale 1ns/1ps
`include "arb_defs.svh"
`define CHECK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
  $display("BAD %0t got %0h exp %0h", $time, g, e); end end
module tb;
  import arb_pkg::*;
  logic        ref_clk_i, rst_i, reg_wr, reg_rd, mmio, ic, reorder, irq, mstart, refr;
  logic [31:0] addr, wdata, rdata;
  logic [9:0]  want, fast, req, ack;
  logic [1:0]  ticks, src;
  logic [3:0]  ovf, unf, munit;
  logic [6:0]  mbytes;
  int          num_errors, n_tests, cyc, busy, total, lat, s1, b, last_ack, last_r, nref;
  int          cnt [10];

  mem_arbiter mem_arbiter_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata),
    .cpu_mmio_req_i(mmio), .cpu_dcache_req_i(req[0]), .cpu_icache_req_i(ic),
    .cpu_reorder_i(reorder), .unit_req_i(req[9:1]), .cpu_ticks_i(ticks),
    .rt_overflow_i(ovf), .rt_underflow_i(unf), .ack_o(ack), .cpu_src_o(src),
    .mem_start_o(mstart), .mem_unit_o(munit), .mem_bytes_o(mbytes), .refresh_o(refr),
    .irq_o(irq));
  req_model req_model_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .want_i(want),
    .fast_i(fast), .ack_i(ack), .req_o(req));

  // Free-running 125 MHz clock
  initial
  begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  // Bus monitor; sampled 1 ns after the edge so design updates have landed
  always @(posedge ref_clk_i)
  begin
    #1;
    cyc++;
    if (ack !== 10'h000)
    begin
      `CHECK($onehot(ack), 1'b1)
      last_ack = $clog2(ack);
      cnt[last_ack]++;
      total++;
    end
    if (mstart === 1'b1 || refr === 1'b1)
      `CHECK(cyc >= busy, 1'b1)
    if (mstart === 1'b1)
    begin
      `CHECK(munit, last_ack[3:0])
      `CHECK(mbytes, 7'h40)
      busy = cyc + `ARB_TXN_CYC + ((munit == 4'h0 && reorder) ? `ARB_REORDER_CYC : 0);
    end
    if (refr === 1'b1)
    begin
      busy = cyc + `ARB_REFR_TXN_CYC;
      if (last_r > 0)
        `CHECK(cyc - last_r <= 72, 1'b1)
      last_r = cyc;
      nref++;
    end
  end

  task automatic stop_test();
    if (num_errors == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  function automatic bit near(input int g, input int n, input int w, input int ws);
    return (g >= n * w / ws - 3) && (g <= n * w / ws + 3);
  endfunction : near

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    addr   <= a;
    wdata  <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data appear in the cycle after the strobe and hold until the next read
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    @(posedge ref_clk_i);
    addr   <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd <= 1'b0;
    #1;
    `CHECK(rdata, e)
  endtask : rd

  // Refresh off after reset so slot timing is exact
  task automatic do_reset();
    @(posedge ref_clk_i);
    rst_i <= 1'b1;
    want  <= 10'h000;
    repeat (4) @(posedge ref_clk_i);
    rst_i  <= 1'b0;
    busy   = 0;
    last_r = 0;
    wr(`ARB_REFRESH_OFF, 32'h0);
  endtask : do_reset

  task automatic wait_ack(input int u);
    lat = 0;
    do
    begin
      @(posedge ref_clk_i);
      #1;
      lat++;
    end
    while (ack[u] !== 1'b1 && lat < 300);
    if (lat >= 300)
    begin
      num_errors++;
      stop_test();
    end
  endtask : wait_ack

  // Counts grants per unit; processor clock ratio varies at random meanwhile
  task automatic run_grants(input int n);
    int k;
    k = 0;
    foreach (cnt[u]) cnt[u] = 0;
    total = 0;
    while (total < n && k < n * 40)
    begin
      @(posedge ref_clk_i);
      ticks <= 2'($urandom_range(3));
      k++;
    end
    if (k >= n * 40)
    begin
      num_errors++;
      stop_test();
    end
  endtask : run_grants

  // Timeout guard against a hung handshake
  initial
  begin
    #400000;
    num_errors++;
    stop_test();
  end

  initial
  begin
    {rst_i, reg_wr, reg_rd, mmio, ic, reorder} = 6'b100000;
    {addr, wdata, want, fast, ovf, unf} = '0;
    ticks = 2'h1;
    void'($urandom(32'hCBDA9248));
    do_reset();
    rd(`ARB_WEIGHT_OFF, 32'h0);
    rd(`ARB_ENABLE_OFF, 32'h3FF);
    rd(`PRIORITY_RAISE_DELAY_REGISTER_OFF, 32'h0);
    rd(`ARB_MASK_OFF, 32'h0);
    rd(32'h0010_01FC, 32'h0);
    // Lone request on an idle bus: ack two edges on, start one after
    @(posedge ref_clk_i);
    want <= 10'h002;
    wait_ack(1);
    `CHECK(lat, 2)
    @(posedge ref_clk_i);
    #1;
    `CHECK(mstart, 1'b1)
    // Saturated traffic: default, reweighted, disabled unit, lowest level
    fast <= 10'h3FF;
    want <= 10'h3FF;
    run_grants(80);
    `CHECK(near(cnt[0], 80, 1, 2), 1'b1)
    `CHECK(near(cnt[1], 80, 1, 4), 1'b1)
    wr(`ARB_WEIGHT_OFF, 32'h0002_0000);
    rd(`ARB_WEIGHT_OFF, 32'h0002_0000);
    run_grants(80);
    `CHECK(near(cnt[0], 80, 3, 4), 1'b1)
    wr(`ARB_WEIGHT_OFF, 32'h0);
    wr(`ARB_ENABLE_OFF, 32'h3FD);
    run_grants(80);
    `CHECK(cnt[1], 0)
    `CHECK(near(cnt[2], 80, 1, 4), 1'b1)
    wr(`ARB_ENABLE_OFF, 32'h060);
    run_grants(60);
    `CHECK(near(cnt[5], 60, 2, 3), 1'b1)
    // Random traffic, data waits and pacing; the monitor judges every slot
    wr(`ARB_ENABLE_OFF, 32'h3FF);
    repeat (40)
    begin
      @(posedge ref_clk_i);
      want <= 10'($urandom);
      fast <= 10'($urandom);
      ticks <= 2'($urandom_range(3));
      repeat (12) @(posedge ref_clk_i);
    end
    // Critical-word reorder lengthens processor slots
    do_reset();
    reorder <= 1'b1;
    want    <= 10'h003;
    run_grants(10);
    reorder <= 1'b0;
    // Raise delay 2 keeps video output low for 32 processor cycles; once raised it
    // still shares level one with the processor, so up to two more decision points
    do_reset();
    wr(`PRIORITY_RAISE_DELAY_REGISTER_OFF, 32'h2);
    ticks <= 2'h1;
    want  <= 10'h003;
    fast  <= 10'h001;
    wait_ack(1);
    `CHECK(lat >= 32 && lat <= 32 + 2 * (`ARB_TXN_CYC + 1) + 4, 1'b1)
    // Two processor sources at once: both served, one at a time
    do_reset();
    mmio <= 1'b1;
    ic   <= 1'b1;
    wait_ack(0);
    s1 = int'(src);
    `CHECK(src, 2'h0)
    @(posedge ref_clk_i);
    if (s1 == 0)
      mmio <= 1'b0;
    else
      ic <= 1'b0;
    wait_ack(0);
    `CHECK(src, (s1 == 0) ? 2'h2 : 2'h0)
    @(posedge ref_clk_i);
    mmio <= 1'b0;
    ic   <= 1'b0;
    // Exception flags: sticky, masked, cleared by writing one
    b = $urandom_range(3);
    @(posedge ref_clk_i);
    ovf <= 4'(1 << b);
    unf <= 4'(1 << b);
    @(posedge ref_clk_i);
    ovf <= 4'h0;
    unf <= 4'h0;
    rd(`ARB_STATUS_OFF, 32'(17 << b));
    `CHECK(irq, 1'b0)
    wr(`ARB_MASK_OFF, 32'hFF);
    #1;
    `CHECK(irq, 1'b1)
    wr(`ARB_STATUS_OFF, 32'(1 << b));
    #1;
    `CHECK(irq, 1'b1)
    wr(`ARB_STATUS_OFF, 32'(16 << b));
    #1;
    `CHECK(irq, 1'b0)
    // Short refresh interval under full load
    wr(`ARB_REFRESH_OFF, 32'd40);
    nref = 0;
    want <= 10'h3FF;
    fast <= 10'h3FF;
    run_grants(30);
    `CHECK(nref >= 3, 1'b1)
    stop_test();
  end
endmodule : tb
